// file: logic/drt_pkg.sv
/* Shared constants and types of the DRAM type and PCI timer register bank.
   Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock. */
package drt_pkg;

	localparam int          DRT_AW         = 12;
	localparam int          DRT_DW         = 32;

	// Register indices; the byte address is four times the index.
	localparam logic [9:0]  DRT_IDX_ROW4   = 10'h067;
	localparam logic [9:0]  DRT_IDX_LOW    = 10'h068;
	localparam logic [9:0]  DRT_IDX_WAIT   = 10'h069;
	localparam logic [9:0]  DRT_IDX_SLICE  = 10'h070;

	localparam logic [7:0]  DRT_RST_ROW4   = 8'h11;
	localparam logic [7:0]  DRT_RST_LOW    = 8'h00;
	localparam logic [7:0]  DRT_RST_WAIT   = 8'h03;
	localparam logic [7:0]  DRT_RST_SLICE  = 8'h20;

	// Writable bits of each register; all others read as zero.
	localparam logic [7:0]  DRT_MSK_ROW4   = 8'h11;
	localparam logic [7:0]  DRT_MSK_LOW    = 8'hFF;
	localparam logic [7:0]  DRT_MSK_WAIT   = 8'h07;
	localparam logic [7:0]  DRT_MSK_SLICE  = 8'hFC;

	localparam int          DRT_TYPE_HI    = 4;
	localparam int          DRT_TYPE_LO    = 0;
	localparam int          DRT_ROWS       = 5;

	// Wait limit used for the reserved codes 1xx, in clocks.
	localparam logic [3:0]  DRT_WAIT_MAX   = 4'h8;

	localparam logic [1:0]  DRT_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  DRT_RESP_SLV   = 2'h2;

	typedef enum logic [1:0] {
		DRT_SPM   = 2'b00,
		DRT_EDO   = 2'b01,
		DRT_SDRAM = 2'b10,
		DRT_OFF   = 2'b11
	} drt_mem_kind_type;

	typedef enum logic [0:0] {
		DRT_WR_IDLE = 1'b0,
		DRT_WR_RESP = 1'b1
	} drt_wr_state_type;

	typedef struct packed {
		logic       start;
		logic [2:0] row;
	} drt_cyc_req_type;

	typedef struct packed {
		logic             go;
		drt_mem_kind_type kind;
		logic [2:0]       row;
	} drt_cyc_out_type;

endpackage : drt_pkg

// file: logic/drt_wait_limit.sv
/* Target wait-state limiter for the burst part of a PCI target transfer.
   Assumes burst and data-ready inputs from logic on the same clock. */
`timescale 1ns/1ns
module drt_wait_limit (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [2:0] wait_limit_code,
	input  wire logic       burst_active,
	input  wire logic       data_ready,
	output logic            target_ready_r
);

	logic [3:0] wait_cnt_r;
	logic [3:0] wait_cnt_nxt;

	function automatic logic [3:0] drt_limit(input logic [2:0] code);
		if (code[2]) begin
			return drt_pkg::DRT_WAIT_MAX;
		end
		return {1'b0, code[1:0], 1'b0} + 4'h2;
	endfunction : drt_limit

	assign wait_cnt_nxt = wait_cnt_r + 4'h1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_cnt_r     <= 4'h0;
			target_ready_r <= 1'b0;
		end else if (!burst_active) begin
			wait_cnt_r     <= 4'h0;
			target_ready_r <= 1'b0;
		end else if (target_ready_r) begin
			wait_cnt_r     <= 4'h0;
			target_ready_r <= data_ready;
		end else begin
			wait_cnt_r     <= wait_cnt_nxt;
			target_ready_r <= data_ready ||
				(wait_cnt_nxt >= drt_limit(wait_limit_code));
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_last_wait;
		burst_active && !target_ready_r &&
		(wait_cnt_nxt == drt_limit(wait_limit_code));
	endsequence

	chk_wait_bound: assert property (
		burst_active && !target_ready_r |->
		wait_cnt_r < drt_limit(wait_limit_code))
	else $error("Target wait exceeded the programmed limit.");

	chk_wait_release: assert property (
		s_last_wait ##1 burst_active |-> target_ready_r)
	else $error("Target ready missing at the wait limit.");

endmodule : drt_wait_limit

// file: logic/drt_time_slice.sv
/* Guaranteed ownership window of the current PCI initiator.
   Assumes grant_start pulses on the first clock of a new grant. */
`timescale 1ns/1ns
module drt_time_slice (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] time_slice_count,
	input  wire logic       grant_start,
	input  wire logic       other_req,
	output logic            handover_r
);

	logic [7:0] remain_r;
	logic [7:0] remain_nxt;
	logic [7:0] elapsed_r;
	logic       slice_off;

	assign slice_off = (time_slice_count == 8'h00);

	always_comb begin
		if (grant_start) begin
			remain_nxt = time_slice_count - 8'h01;
		end else if (remain_r != 8'h00) begin
			remain_nxt = remain_r - 8'h01;
		end else begin
			remain_nxt = 8'h00;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remain_r <= 8'h00;
		end else begin
			remain_r <= slice_off ? 8'h00 : remain_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			handover_r <= 1'b0;
		end else begin
			handover_r <= other_req && !grant_start &&
				(slice_off || remain_nxt == 8'h00);
		end
	end

	// The elapsed count only feeds the checks below.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			elapsed_r <= 8'hFF;
		end else if (grant_start) begin
			elapsed_r <= 8'h01;
		end else if (elapsed_r != 8'hFF) begin
			elapsed_r <= elapsed_r + 8'h01;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_slice_hold: assert property (
		handover_r |-> slice_off || elapsed_r >= time_slice_count)
	else $error("Grant handed over inside the time slice.");

	chk_slice_expire: assert property (
		!grant_start && remain_r == 8'h00 && other_req |=>
		handover_r)
	else $error("No handover after the slice expired.");

	chk_slice_off: assert property (
		slice_off && other_req && !grant_start |=> handover_r)
	else $error("Disabled slice still held the bus.");

endmodule : drt_time_slice

// file: logic/drt_regs_top.sv
/* DRAM row type and PCI timer registers behind an AXI4-Lite slave, with
   the row type lookup, the target wait limiter and the time slice.
   Assumes all request inputs come from logic on aclk. */
`timescale 1ns/1ns
module drt_regs_top (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic [11:0]              s_axi_awaddr,
	input  wire logic [2:0]               s_axi_awprot,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [11:0]              s_axi_araddr,
	input  wire logic [2:0]               s_axi_arprot,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire drt_pkg::drt_cyc_req_type cyc_req,
	output drt_pkg::drt_cyc_out_type      cyc_out_r,
	output logic                          row4_pins_active_r,
	input  wire logic                     burst_active,
	input  wire logic                     burst_data_ready,
	output logic                          target_ready_r,
	input  wire logic                     grant_start,
	input  wire logic                     other_req,
	output logic                          handover_r
);

	localparam logic [2:0] SEL_NONE  = 3'h0;
	localparam logic [2:0] SEL_ROW4  = 3'h1;
	localparam logic [2:0] SEL_LOW   = 3'h2;
	localparam logic [2:0] SEL_WAIT  = 3'h3;
	localparam logic [2:0] SEL_SLICE = 3'h4;

	drt_pkg::drt_wr_state_type wr_state_r;
	logic [7:0]                row4_type_reg_r;
	logic [7:0]                rows_low_type_reg_r;
	logic [7:0]                target_wait_limit_reg_r;
	logic [7:0]                time_slice_reg_r;
	logic                      aw_held_r;
	logic                      w_held_r;
	logic [11:0]               aw_addr_r;
	logic [7:0]                w_byte_r;
	logic                      w_lane_r;
	logic [2:0]                wr_sel;
	logic                      wr_fire;
	logic [2:0]                rd_sel;
	logic [7:0]                rd_byte;
	drt_pkg::drt_mem_kind_type row_kind [drt_pkg::DRT_ROWS];
	drt_pkg::drt_mem_kind_type row_kind_sel;
	logic                      row_usable;

	function automatic logic [2:0] drt_sel(input logic [11:0] a);
		case (a[11:2])
			drt_pkg::DRT_IDX_ROW4:  return SEL_ROW4;
			drt_pkg::DRT_IDX_LOW:   return SEL_LOW;
			drt_pkg::DRT_IDX_WAIT:  return SEL_WAIT;
			drt_pkg::DRT_IDX_SLICE: return SEL_SLICE;
			default:                return SEL_NONE;
		endcase
	endfunction : drt_sel

	// Write address and data are taken in either order and held here.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_byte_r <= 8'h00;
			w_lane_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_byte_r <= s_axi_wdata[7:0];
			w_lane_r <= s_axi_wstrb[0];
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_held_r <= 1'b0;
		end
	end

	// Ready drops on acceptance so a second beat cannot overrun the hold.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	assign wr_sel  = drt_sel(aw_addr_r);
	assign wr_fire = aw_held_r && w_held_r &&
		(wr_state_r == drt_pkg::DRT_WR_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_r   <= drt_pkg::DRT_WR_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= drt_pkg::DRT_RESP_OKAY;
		end else begin
			case (wr_state_r)
				drt_pkg::DRT_WR_IDLE: begin
					if (wr_fire) begin
						wr_state_r   <= drt_pkg::DRT_WR_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= (wr_sel == SEL_NONE) ?
							drt_pkg::DRT_RESP_SLV :
							drt_pkg::DRT_RESP_OKAY;
					end
				end
				drt_pkg::DRT_WR_RESP: begin
					if (s_axi_bready) begin
						wr_state_r   <= drt_pkg::DRT_WR_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
				default: begin
					wr_state_r   <= drt_pkg::DRT_WR_IDLE;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			row4_type_reg_r <= drt_pkg::DRT_RST_ROW4;
		end else if (wr_fire && w_lane_r && wr_sel == SEL_ROW4) begin
			row4_type_reg_r <= w_byte_r & drt_pkg::DRT_MSK_ROW4;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rows_low_type_reg_r <= drt_pkg::DRT_RST_LOW;
		end else if (wr_fire && w_lane_r && wr_sel == SEL_LOW) begin
			rows_low_type_reg_r <= w_byte_r & drt_pkg::DRT_MSK_LOW;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			target_wait_limit_reg_r <= drt_pkg::DRT_RST_WAIT;
		end else if (wr_fire && w_lane_r && wr_sel == SEL_WAIT) begin
			target_wait_limit_reg_r <= w_byte_r & drt_pkg::DRT_MSK_WAIT;
		end
	end

	// low two bits held at zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			time_slice_reg_r <= drt_pkg::DRT_RST_SLICE;
		end else if (wr_fire && w_lane_r && wr_sel == SEL_SLICE) begin
			time_slice_reg_r <= w_byte_r & drt_pkg::DRT_MSK_SLICE;
		end
	end

	// Reads answer one clock after the address is taken.
	assign rd_sel = drt_sel(s_axi_araddr);

	always_comb begin
		case (rd_sel)
			SEL_ROW4:  rd_byte = row4_type_reg_r;
			SEL_LOW:   rd_byte = rows_low_type_reg_r;
			SEL_WAIT:  rd_byte = target_wait_limit_reg_r;
			SEL_SLICE: rd_byte = time_slice_reg_r;
			default:   rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= drt_pkg::DRT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, rd_byte};
			s_axi_rresp   <= (rd_sel == SEL_NONE) ?
				drt_pkg::DRT_RESP_SLV : drt_pkg::DRT_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// reserved pair falls back to page mode
	for (genvar g = 0; g < 4; g++) begin : g_low_rows
		logic [1:0] pair;
		assign pair = {rows_low_type_reg_r[g + drt_pkg::DRT_TYPE_HI],
			rows_low_type_reg_r[g + drt_pkg::DRT_TYPE_LO]};
		assign row_kind[g] = (pair == 2'b11) ? drt_pkg::DRT_SPM :
			drt_pkg::drt_mem_kind_type'(pair);
	end

	// row 4 field from bits 4 and 0
	assign row_kind[4] = drt_pkg::drt_mem_kind_type'(
		{row4_type_reg_r[drt_pkg::DRT_TYPE_HI],
		row4_type_reg_r[drt_pkg::DRT_TYPE_LO]});

	always_comb begin
		row_kind_sel = drt_pkg::DRT_SPM;
		row_usable   = 1'b0;
		case (cyc_req.row)
			3'h0, 3'h1, 3'h2, 3'h3: begin
				row_kind_sel = row_kind[cyc_req.row[1:0]];
				row_usable   = 1'b1;
			end
			3'h4: begin
				row_kind_sel = row_kind[4];
				row_usable   = (row_kind[4] != drt_pkg::DRT_OFF);
			end
			default: begin
				row_kind_sel = drt_pkg::DRT_SPM;
				row_usable   = 1'b0;
			end
		endcase
	end

	// type looked up at cycle start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_out_r <= '{go: 1'b0, kind: drt_pkg::DRT_SPM, row: 3'h0};
		end else begin
			cyc_out_r.go   <= cyc_req.start && row_usable;
			cyc_out_r.kind <= row_kind_sel;
			cyc_out_r.row  <= cyc_req.row;
		end
	end

	// row 4 pins follow the register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			row4_pins_active_r <= 1'b0;
		end else begin
			row4_pins_active_r <=
				(row4_type_reg_r != drt_pkg::DRT_RST_ROW4);
		end
	end

	drt_wait_limit u_wait (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.wait_limit_code (target_wait_limit_reg_r[2:0]),
		.burst_active    (burst_active),
		.data_ready      (burst_data_ready),
		.target_ready_r  (target_ready_r)
	);

	drt_time_slice u_slice (
		.aclk             (aclk),
		.aresetn          (aresetn),
		.time_slice_count (time_slice_reg_r),
		.grant_start      (grant_start),
		.other_req        (other_req),
		.handover_r       (handover_r)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_row4_start;
		cyc_req.start && cyc_req.row == 3'h4;
	endsequence

	chk_row4_off: assert property (
		s_row4_start and (row4_type_reg_r[4] && row4_type_reg_r[0])
		|=> !cyc_out_r.go)
	else $error("Cycle started on a disabled row 4.");

	chk_row4_pins: assert property (
		row4_type_reg_r != drt_pkg::DRT_RST_ROW4 ##1
		row4_type_reg_r != drt_pkg::DRT_RST_ROW4 |->
		row4_pins_active_r)
	else $error("Row 4 pins not switched for a changed type.");

	chk_cycle_kind: assert property (
		s_row4_start and !(row4_type_reg_r[4] && row4_type_reg_r[0])
		|=> cyc_out_r.go && cyc_out_r.kind ==
		{$past(row4_type_reg_r[4]), $past(row4_type_reg_r[0])})
	else $error("Row 4 cycle ran with the wrong type.");

	chk_low_pairs: assert property (
		cyc_req.start && cyc_req.row == 3'h3 &&
		!(rows_low_type_reg_r[7] && rows_low_type_reg_r[3]) |=>
		cyc_out_r.go && cyc_out_r.kind ==
		{$past(rows_low_type_reg_r[7]), $past(rows_low_type_reg_r[3])})
	else $error("Row 3 type not taken from bits 7 and 3.");

	chk_pair_reserved: assert property (
		cyc_req.start && cyc_req.row == 3'h2 &&
		rows_low_type_reg_r[6] && rows_low_type_reg_r[2] |=>
		cyc_out_r.kind == drt_pkg::DRT_SPM)
	else $error("Reserved row type not run as page mode.");

	chk_slice_low_zero: assert property (
		time_slice_reg_r[1:0] == 2'b00)
	else $error("Time slice low bits not zero.");

	chk_read_reserved: assert property (
		s_axi_arvalid && s_axi_arready |=>
		s_axi_rdata[31:8] == 24'h000000 &&
		($past(rd_sel) != SEL_ROW4 ||
		(s_axi_rdata[7:0] & ~drt_pkg::DRT_MSK_ROW4) == 8'h00) &&
		($past(rd_sel) != SEL_WAIT ||
		(s_axi_rdata[7:0] & ~drt_pkg::DRT_MSK_WAIT) == 8'h00))
	else $error("Read returned reserved bits set.");

	chk_write_answer: assert property (
		wr_fire |=> s_axi_bvalid ##0 $stable(aw_addr_r))
	else $error("Write response missing after both halves.");

endmodule : drt_regs_top

// file: tb/drt_far_model.sv
/* Far-side model: a PCI initiator and a bursting master on the bank's
   arbiter and target lines. Assumes bench commands arrive on aclk. */
`timescale 1ns/1ns
module drt_far_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic cmd_grant,
	input  wire logic cmd_req,
	input  wire logic cmd_burst,
	input  wire logic cmd_slow,
	output logic      grant_start,
	output logic      other_req,
	output logic      burst_active,
	output logic      burst_data_ready
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			grant_start <= 1'b0;
			other_req <= 1'b0;
			burst_active <= 1'b0;
			burst_data_ready <= 1'b0;
		end else begin
			grant_start <= cmd_grant;
			other_req <= cmd_req;
			burst_active <= cmd_burst;
			// Outside a burst nobody holds the line, so it toggles.
			burst_data_ready <= cmd_burst ? !cmd_slow : !burst_data_ready;
		end
	end
endmodule : drt_far_model

// file: tb/tb_top.sv
/* Self-checking bench of the DRAM type and PCI timer register bank.
   Assumes the far-side model drives the arbiter and burst lines. */
`timescale 1ns/1ns
module tb_top;
	localparam logic [11:0] a_row4  = {drt_pkg::DRT_IDX_ROW4, 2'h0};
	localparam logic [11:0] a_low   = {drt_pkg::DRT_IDX_LOW, 2'h0};
	localparam logic [11:0] a_wait  = {drt_pkg::DRT_IDX_WAIT, 2'h0};
	localparam logic [11:0] a_slice = {drt_pkg::DRT_IDX_SLICE, 2'h0};
	logic                     aclk;
	logic                     aresetn;
	logic [11:0]              awaddr;
	logic [11:0]              araddr;
	logic [31:0]              wdata;
	logic [31:0]              rdata;
	logic [1:0]               bresp;
	logic [1:0]               rresp;
	logic                     awvalid;
	logic                     awready;
	logic                     wvalid;
	logic                     wready;
	logic                     bvalid;
	logic                     bready;
	logic                     arvalid;
	logic                     arready;
	logic                     rvalid;
	logic                     rready;
	drt_pkg::drt_cyc_req_type cyc_req;
	drt_pkg::drt_cyc_out_type cyc_out;
	logic                     r4_act;
	logic                     t_rdy;
	logic                     hand;
	logic                     gs;
	logic                     oreq;
	logic                     bact;
	logic                     bdr;
	logic                     c_grant;
	logic                     c_req;
	logic                     c_burst;
	logic                     c_slow;
	int                       fail_count;
	int                       check_count;
	int                       cyc;

	drt_regs_top dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cyc_req(cyc_req), .cyc_out_r(cyc_out),
		.row4_pins_active_r(r4_act), .burst_active(bact),
		.burst_data_ready(bdr), .target_ready_r(t_rdy),
		.grant_start(gs), .other_req(oreq), .handover_r(hand)
	);

	drt_far_model far (
		.aclk(aclk), .aresetn(aresetn), .cmd_grant(c_grant),
		.cmd_req(c_req), .cmd_burst(c_burst), .cmd_slow(c_slow),
		.grant_start(gs), .other_req(oreq), .burst_active(bact),
		.burst_data_ready(bdr)
	);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		logic b_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		b_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_ok) begin
			@(posedge aclk);
			if (awready)
				aw_ok = 1'b1;
			if (wready)
				w_ok = 1'b1;
			awvalid <= !aw_ok;
			wvalid <= !w_ok;
			if (bvalid) begin
				b_ok = 1'b1;
				bready <= 1'b0;
				check(32'(bresp), 32'(er));
			end
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		check(rdata, ed);
		check(32'(rresp), 32'(er));
	endtask : axi_rd

	task automatic t_regs;
		axi_rd(a_row4, 32'h11, 2'h0);
		axi_rd(a_low, 32'h00, 2'h0);
		axi_rd(a_wait, 32'h03, 2'h0);
		axi_rd(a_slice, 32'h20, 2'h0);
		check(32'(r4_act), 32'h0);
		axi_wr(a_row4, 32'hFF, 2'h0);
		axi_rd(a_row4, 32'h11, 2'h0);
		axi_wr(a_low, 32'hFFFF_FFFF, 2'h0);
		axi_rd(a_low, 32'hFF, 2'h0);
		axi_wr(a_wait, 32'hFF, 2'h0);
		axi_rd(a_wait, 32'h07, 2'h0);
		axi_wr(12'h004, 32'h55, 2'h2);
		axi_rd(12'h004, 32'h0, 2'h2);
		axi_wr(a_row4, 32'h01, 2'h0);
		@(posedge aclk);
		#1;
		check(32'(r4_act), 32'h1);
		axi_wr(a_row4, 32'h11, 2'h0);
		@(posedge aclk);
		#1;
		check(32'(r4_act), 32'h0);
		$display("test regs done");
	endtask : t_regs

	task automatic cyc_chk(input logic [2:0] r, input logic g,
		input logic [1:0] k);
		@(posedge aclk);
		cyc_req <= '{start: 1'b1, row: r};
		@(posedge aclk);
		cyc_req <= '{start: 1'b0, row: r};
		#1;
		check(32'(cyc_out.go), 32'(g));
		if (g)
			check(32'({cyc_out.kind, cyc_out.row}), 32'({k, r}));
		@(posedge aclk);
		#1;
		check(32'(cyc_out.go), 32'h0);
	endtask : cyc_chk

	task automatic t_rows;
		logic [7:0] lw;
		logic [1:0] k;
		lw = 8'hE5;
		axi_wr(a_low, 32'(lw), 2'h0);
		axi_wr(a_row4, 32'h10, 2'h0);
		for (int r = 0; r < 4; r++) begin
			k = {lw[r + 4], lw[r]};
			cyc_chk(3'(r), 1'b1, (k == 2'h3) ? 2'h0 : k);
		end
		cyc_chk(3'h4, 1'b1, 2'h2);
		axi_wr(a_row4, 32'h01, 2'h0);
		cyc_chk(3'h4, 1'b1, 2'h1);
		cyc_chk(3'h5, 1'b0, 2'h0);
		axi_wr(a_row4, 32'h11, 2'h0);
		cyc_chk(3'h4, 1'b0, 2'h0);
		$display("test rows done");
	endtask : t_rows

	task automatic t_wait;
		int n;
		int lim;
		for (int c = 0; c < 6; c++) begin
			lim = (c == 5) ? 1 : (c > 3) ? 8 : 2 * c + 2;
			axi_wr(a_wait, (c == 5) ? 32'h3 : 32'(c), 2'h0);
			@(posedge aclk);
			c_slow <= (c != 5);
			c_burst <= 1'b1;
			do begin
				@(posedge aclk);
				#1;
			end while (!bact);
			n = 0;
			while (!t_rdy && n < 20) begin
				n++;
				@(posedge aclk);
				#1;
			end
			check(32'(n), 32'(lim));
			@(posedge aclk);
			c_burst <= 1'b0;
			repeat (3) @(posedge aclk);
		end
		$display("test wait done");
	endtask : t_wait

	task automatic t_slice(input logic [7:0] v, input int nn, input int d);
		int n;
		int k;
		axi_wr(a_slice, 32'(v), 2'h0);
		axi_rd(a_slice, 32'(v & 8'hFC), 2'h0);
		@(posedge aclk);
		c_grant <= 1'b1;
		c_req <= (d == 0);
		@(posedge aclk);
		c_grant <= 1'b0;
		#1;
		n = 0;
		k = -1;
		while (!hand && n < 100) begin
			if (oreq && k < 0)
				k = n;
			n++;
			@(posedge aclk);
			if (n == d)
				c_req <= 1'b1;
			#1;
		end
		check(32'(n), 32'((nn > k) ? nn : k + 1));
		@(posedge aclk);
		c_req <= 1'b0;
		repeat (3) @(posedge aclk);
		$display("test slice %h done", v);
	endtask : t_slice

	initial begin
		cyc = 0;
		forever begin
			@(posedge aclk);
			cyc++;
			if (cyc >= 20000) begin
				fail_count++;
				finish_test;
			end
		end
	end

	initial begin
		fail_count = 0;
		check_count = 0;
		aresetn = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{c_grant, c_req, c_burst, c_slow} = '0;
		cyc_req = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_rows;
		t_wait;
		t_slice(8'h20, 32, 0);
		t_slice(8'h0B, 8, 0);
		t_slice(8'h08, 8, 12);
		t_slice(8'h00, 0, 3);
		finish_test;
	end
endmodule : tb_top
